/* File: rtl/bst_regs.vh */
// constants of the boundary-scan test port
`ifndef BST_REGS_VH
`define BST_REGS_VH

// ----------------------------------------
// instruction register
// ----------------------------------------
`define BST_IR_W 10
`define BST_IR_EXTEST 10'h000
`define BST_IR_CFG 10'h002
`define BST_IR_SAMPLE 10'h005
`define BST_IR_IDCODE 10'h006
`define BST_IR_USERCODE 10'h007
`define BST_IR_BYPASS 10'h3FF
`define BST_IR_CAPTURE 10'h001

// ----------------------------------------
// identification and signature layout
// ----------------------------------------
`define BST_ID_W 32
// version, part and maker values are arbitrary
`define BST_ID_VERSION 4'hA
`define BST_ID_PART 16'h5A3C
`define BST_ID_MAKER 11'h2B5
`define BST_USER_BITS 7
// fixed signature bits are arbitrary
`define BST_USER_FIXED 25'h0123456

// ----------------------------------------
// boundary register lengths per variant
// ----------------------------------------
`define BST_BSR_LEN_V0 690
`define BST_BSR_LEN_V1 798
`define BST_BSR_LEN_V2 1050
`define BST_BSR_LEN_V3 1308
`define BST_BSR_LEN_V4 1446
`define BST_BSR_LEN `BST_BSR_LEN_V0

// ----------------------------------------
// configuration stream
// ----------------------------------------
`define BST_CFG_W 8
`define BST_CFG_CNT_W 3
`define BST_CFG_LAST 3'h7

`endif

/* File: rtl/bst_buf.v */
// two-entry buffer for configuration bytes
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_buf #(
    parameter WIDTH = `BST_CFG_W
) (
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire in_valid_in,
    input wire [WIDTH-1:0] in_data_in,
    output wire in_ready_out,
    output reg out_valid_out,
    output reg [WIDTH-1:0] out_data_out,
    input wire out_ready_in
);
    reg spare_valid;
    reg [WIDTH-1:0] spare_data;
    wire push;
    wire pop;

    assign in_ready_out = ~spare_valid;
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    always @(posedge clk_in) begin
        if (rst_in) begin
            out_valid_out <= 1'b0;
            out_data_out <= {WIDTH{1'b0}};
            spare_valid <= 1'b0;
            spare_data <= {WIDTH{1'b0}};
        end else if (ce_in) begin
            if (!out_valid_out || pop) begin
                if (spare_valid) begin
                    out_data_out <= spare_data;
                    out_valid_out <= 1'b1;
                    spare_valid <= 1'b0;
                end else begin
                    out_valid_out <= push;
                    out_data_out <= in_data_in;
                end
            end else if (push) begin
                spare_valid <= 1'b1;
                spare_data <= in_data_in;
            end
        end
    end
endmodule

/* File: rtl/bst_tap.v */
// boundary-scan test access port with tap controller and data registers
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_tap (
    input wire ref_clk_in,
    input wire rst_in,
    input wire clk_en_in,
    input wire tck_in,
    input wire tms_pad_in,
    input wire tms_driven_in,
    input wire tdi_pad_in,
    input wire tdi_driven_in,
    output reg tdo_out,
    output reg tdo_oe_n_out,
    input wire [`BST_USER_BITS-1:0] user_sig_in,
    input wire [`BST_BSR_LEN-1:0] pin_level_in,
    input wire [`BST_BSR_LEN-1:0] core_out_in,
    output reg [`BST_BSR_LEN-1:0] pin_out,
    output reg extest_out,
    output reg cfg_active_out,
    output reg cfg_overrun_out,
    output wire cfg_valid_out,
    output wire [`BST_CFG_W-1:0] cfg_data_out,
    input wire cfg_ready_in
);
    // ----------------------------------------
    // tap states
    // ----------------------------------------
    localparam [15:0] S_RESET = 16'h0001;
    localparam [15:0] S_IDLE = 16'h0002;
    localparam [15:0] S_SEL_DR = 16'h0004;
    localparam [15:0] S_CAP_DR = 16'h0008;
    localparam [15:0] S_SH_DR = 16'h0010;
    localparam [15:0] S_EX1_DR = 16'h0020;
    localparam [15:0] S_PAU_DR = 16'h0040;
    localparam [15:0] S_EX2_DR = 16'h0080;
    localparam [15:0] S_UPD_DR = 16'h0100;
    localparam [15:0] S_SEL_IR = 16'h0200;
    localparam [15:0] S_CAP_IR = 16'h0400;
    localparam [15:0] S_SH_IR = 16'h0800;
    localparam [15:0] S_EX1_IR = 16'h1000;
    localparam [15:0] S_PAU_IR = 16'h2000;
    localparam [15:0] S_EX2_IR = 16'h4000;
    localparam [15:0] S_UPD_IR = 16'h8000;
    localparam BSR_LEN = `BST_BSR_LEN;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg tck_s1, tck_s2, tck_s3;
    reg tms_s1, tms_s2;
    reg tdi_s1, tdi_s2;
    reg [BSR_LEN-1:0] pin_s1, pin_s2;
    wire tck_rise;
    wire tck_fall;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
            pin_s1 <= {BSR_LEN{1'b0}};
            pin_s2 <= {BSR_LEN{1'b0}};
        end else if (clk_en_in) begin
            tck_s1 <= tck_in;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= tms_driven_in ? tms_pad_in : 1'b1;
            tms_s2 <= tms_s1;
            tdi_s1 <= tdi_driven_in ? tdi_pad_in : 1'b1;
            tdi_s2 <= tdi_s1;
            pin_s1 <= pin_level_in;
            pin_s2 <= pin_s1;
        end
    end

    assign tck_rise = clk_en_in & tck_s2 & ~tck_s3;
    assign tck_fall = clk_en_in & ~tck_s2 & tck_s3;

    // ----------------------------------------
    // tap controller
    // ----------------------------------------
    reg [15:0] state;
    reg [15:0] next_state;

    always @* begin
        case (state)
            S_RESET: next_state = tms_s2 ? S_RESET : S_IDLE;
            S_IDLE: next_state = tms_s2 ? S_SEL_DR : S_IDLE;
            S_SEL_DR: next_state = tms_s2 ? S_SEL_IR : S_CAP_DR;
            S_CAP_DR: next_state = tms_s2 ? S_EX1_DR : S_SH_DR;
            S_SH_DR: next_state = tms_s2 ? S_EX1_DR : S_SH_DR;
            S_EX1_DR: next_state = tms_s2 ? S_UPD_DR : S_PAU_DR;
            S_PAU_DR: next_state = tms_s2 ? S_EX2_DR : S_PAU_DR;
            S_EX2_DR: next_state = tms_s2 ? S_UPD_DR : S_SH_DR;
            S_UPD_DR: next_state = tms_s2 ? S_SEL_DR : S_IDLE;
            S_SEL_IR: next_state = tms_s2 ? S_RESET : S_CAP_IR;
            S_CAP_IR: next_state = tms_s2 ? S_EX1_IR : S_SH_IR;
            S_SH_IR: next_state = tms_s2 ? S_EX1_IR : S_SH_IR;
            S_EX1_IR: next_state = tms_s2 ? S_UPD_IR : S_PAU_IR;
            S_PAU_IR: next_state = tms_s2 ? S_EX2_IR : S_PAU_IR;
            S_EX2_IR: next_state = tms_s2 ? S_UPD_IR : S_SH_IR;
            S_UPD_IR: next_state = tms_s2 ? S_SEL_DR : S_IDLE;
            default: next_state = S_RESET;
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            state <= S_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // instruction register and decode
    // ----------------------------------------
    reg [`BST_IR_W-1:0] ir_sr;
    reg [`BST_IR_W-1:0] ir;
    wire sel_extest;
    wire sel_sample;
    wire sel_id;
    wire sel_user;
    wire sel_cfg;
    wire sel_bsr;
    wire sel_bypass;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            ir_sr <= {`BST_IR_W{1'b0}};
            ir <= `BST_IR_IDCODE;
        end else if (clk_en_in) begin
            if (state == S_RESET) begin
                ir <= `BST_IR_IDCODE;
            end else if (tck_fall && state == S_UPD_IR) begin
                ir <= ir_sr;
            end
            if (tck_rise && state == S_CAP_IR) begin
                ir_sr <= `BST_IR_CAPTURE;
            end else if (tck_rise && state == S_SH_IR) begin
                ir_sr <= {tdi_s2, ir_sr[`BST_IR_W-1:1]};
            end
        end
    end

    assign sel_extest = (ir == `BST_IR_EXTEST);
    assign sel_sample = (ir == `BST_IR_SAMPLE);
    assign sel_id = (ir == `BST_IR_IDCODE);
    assign sel_user = (ir == `BST_IR_USERCODE);
    assign sel_cfg = (ir == `BST_IR_CFG);
    assign sel_bsr = sel_extest | sel_sample;
    // all ones and every unknown code land on bypass
    assign sel_bypass = ~(sel_bsr | sel_id | sel_user | sel_cfg);

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    reg bypass_sr;
    reg [`BST_ID_W-1:0] word_sr;
    reg [BSR_LEN-1:0] bsr_sr;
    reg [BSR_LEN-1:0] bsr_upd;
    wire [`BST_ID_W-1:0] id_value;
    wire [`BST_ID_W-1:0] user_value;

    assign id_value = {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1};
    assign user_value = {`BST_USER_FIXED, user_sig_in};

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            bypass_sr <= 1'b0;
            word_sr <= {`BST_ID_W{1'b0}};
            bsr_sr <= {BSR_LEN{1'b0}};
            bsr_upd <= {BSR_LEN{1'b0}};
        end else if (clk_en_in) begin
            if (tck_rise && state == S_CAP_DR) begin
                bypass_sr <= 1'b0;
                if (sel_id) begin
                    word_sr <= id_value;
                end else if (sel_user) begin
                    word_sr <= user_value;
                end
                if (sel_bsr) begin
                    bsr_sr <= pin_s2;
                end
            end else if (tck_rise && state == S_SH_DR) begin
                bypass_sr <= tdi_s2;
                if (sel_id || sel_user) begin
                    word_sr <= {tdi_s2, word_sr[`BST_ID_W-1:1]};
                end
                if (sel_bsr) begin
                    bsr_sr <= {tdi_s2, bsr_sr[BSR_LEN-1:1]};
                end
            end
            if (tck_fall && state == S_UPD_DR && sel_bsr) begin
                bsr_upd <= bsr_sr;
            end
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            pin_out <= {BSR_LEN{1'b0}};
            extest_out <= 1'b0;
        end else if (clk_en_in) begin
            // outside extest the core owns the pins, so sampling leaves them alone
            extest_out <= sel_extest & (state != S_RESET);
            if (sel_extest && state != S_RESET) begin
                pin_out <= bsr_upd;
            end else begin
                pin_out <= core_out_in;
            end
        end
    end

    // ----------------------------------------
    // configuration stream
    // ----------------------------------------
    reg [`BST_CFG_W-1:0] cfg_sr;
    reg [`BST_CFG_CNT_W-1:0] cfg_cnt;
    reg [`BST_CFG_W-1:0] cfg_byte;
    reg cfg_pend;
    wire cfg_ready;
    wire cfg_done;

    assign cfg_done = tck_rise && state == S_SH_DR && sel_cfg && cfg_cnt == `BST_CFG_LAST;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            cfg_sr <= {`BST_CFG_W{1'b0}};
            cfg_cnt <= {`BST_CFG_CNT_W{1'b0}};
            cfg_byte <= {`BST_CFG_W{1'b0}};
            cfg_pend <= 1'b0;
            cfg_overrun_out <= 1'b0;
            cfg_active_out <= 1'b0;
        end else if (clk_en_in) begin
            cfg_active_out <= sel_cfg & (state != S_RESET);
            if (tck_rise && state == S_CAP_DR) begin
                cfg_cnt <= {`BST_CFG_CNT_W{1'b0}};
            end else if (tck_rise && state == S_SH_DR && sel_cfg) begin
                cfg_sr <= {tdi_s2, cfg_sr[`BST_CFG_W-1:1]};
                cfg_cnt <= cfg_cnt + 3'h1;
            end
            // a finished byte waits here while the buffer is full
            if (cfg_done) begin
                cfg_byte <= {tdi_s2, cfg_sr[`BST_CFG_W-1:1]};
                cfg_pend <= 1'b1;
            end else if (cfg_ready) begin
                cfg_pend <= 1'b0;
            end
            // a new byte overwrites one still pending, so the older one is lost; flag it
            if (cfg_done && cfg_pend && !cfg_ready) begin
                cfg_overrun_out <= 1'b1;
            end else if (state == S_RESET) begin
                cfg_overrun_out <= 1'b0;
            end
        end
    end

    bst_buf #(
        .WIDTH(`BST_CFG_W)
    ) u_buf (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(clk_en_in),
        .in_valid_in(cfg_pend),
        .in_data_in(cfg_byte),
        .in_ready_out(cfg_ready),
        .out_valid_out(cfg_valid_out),
        .out_data_out(cfg_data_out),
        .out_ready_in(cfg_ready_in)
    );

    // ----------------------------------------
    // serial output, changes on the falling test clock
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            tdo_out <= 1'b1;
            tdo_oe_n_out <= 1'b1;
        end else if (tck_fall) begin
            if (state == S_SH_IR) begin
                tdo_out <= ir_sr[0];
                tdo_oe_n_out <= 1'b0;
            end else if (state == S_SH_DR) begin
                tdo_oe_n_out <= 1'b0;
                if (sel_bsr) begin
                    tdo_out <= bsr_sr[0];
                end else if (sel_id || sel_user) begin
                    tdo_out <= word_sr[0];
                end else if (sel_cfg) begin
                    tdo_out <= cfg_sr[0];
                end else begin
                    tdo_out <= bypass_sr;
                end
            end else begin
                tdo_oe_n_out <= 1'b1;
            end
        end
    end
endmodule

/* File: tb/bst_checker.sv */
// concurrent checks on the boundary-scan test port pins
`timescale 1ns/1ps
`include "bst_regs.vh"
module bst_checker (
    input wire ref_clk_in,
    input wire rst_in,
    input wire clk_en_in,
    input wire tck_in,
    input wire tdo_out,
    input wire tdo_oe_n_out,
    input wire [`BST_BSR_LEN-1:0] core_out_in,
    input wire [`BST_BSR_LEN-1:0] pin_out,
    input wire extest_out,
    input wire cfg_active_out,
    input wire cfg_valid_out,
    input wire [`BST_CFG_W-1:0] cfg_data_out,
    input wire cfg_ready_in
);
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    a_reset_quiet:
    assert property ($fell(rst_in) |-> tdo_oe_n_out && !extest_out && !cfg_active_out
        && !cfg_valid_out) else $error("port not idle after reset");
    a_tdo_at_fall:
    assert property ($changed(tdo_out) |-> !$past(tck_in, 3) || !$past(tck_in, 4))
        else $error("data out moved away from a test clock fall");
    a_oe_at_fall:
    assert property ($changed(tdo_oe_n_out) |-> !$past(tck_in, 3) || !$past(tck_in, 4))
        else $error("output enable moved away from a test clock fall");
    a_pins_follow_core:
    assert property (!extest_out && !$past(extest_out) && !$past(rst_in) && $past(clk_en_in)
        |-> pin_out == $past(core_out_in)) else $error("pins disturbed outside extest");
    a_pins_hold_extest:
    assert property (extest_out && $past(extest_out) && $changed(core_out_in)
        |=> $stable(pin_out)) else $error("pins follow core under extest");
    a_cfg_stall_hold:
    assert property (cfg_valid_out && !cfg_ready_in |=> cfg_valid_out && $stable(cfg_data_out))
        else $error("config byte lost during stall");
    a_cfg_source:
    assert property ($rose(cfg_valid_out) |-> cfg_active_out)
        else $error("config byte outside config instruction");
    a_one_instr:
    assert property (extest_out |-> !cfg_active_out) else $error("two instructions active");
endmodule

bind bst_tap bst_checker bst_checker_inst (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .tck_in(tck_in),
    .tdo_out(tdo_out),
    .tdo_oe_n_out(tdo_oe_n_out),
    .core_out_in(core_out_in),
    .pin_out(pin_out),
    .extest_out(extest_out),
    .cfg_active_out(cfg_active_out),
    .cfg_valid_out(cfg_valid_out),
    .cfg_data_out(cfg_data_out),
    .cfg_ready_in(cfg_ready_in)
);

/* File: tb/bst_jtag_host.sv */
// model of the external test controller driving the test port
`timescale 1ns/1ps
module bst_jtag_host (
    input wire ref_clk_in,
    input wire tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tms_drv_out,
    output logic tdi_out,
    output logic tdi_drv_out
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tms_drv_out = 1'b1;
        tdi_out = 1'b1;
        tdi_drv_out = 1'b0;
    end

    // ----------------------------------------
    // test clock periods of 8 ref clocks
    // ----------------------------------------
    // a released line shows the inverse of its last value
    task automatic step(input logic tms, input logic tdi, input logic drv, output logic tdo);
        tms_out = tms_drv_out ? tms : ~tms_out;
        tdi_drv_out = drv;
        tdi_out = drv ? tdi : ~tdi_out;
        repeat (4) @(posedge ref_clk_in);
        #1 tck_out = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        tdo = tdo_in;
        repeat (2) @(posedge ref_clk_in);
        #1 tck_out = 1'b0;
    endtask

    task automatic nav(input logic tms);
        logic d;
        step(tms, 1'b0, 1'b0, d);
    endtask

    // from idle, shift n bits lsb first through ir or dr, back to idle
    task automatic scan(input logic ir, input int n, input logic [1023:0] din,
                        output logic [1023:0] dout);
        logic b;
        dout = '0;
        nav(1'b1);
        if (ir) nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], 1'b1, b);
            dout[i] = b;
        end
        nav(1'b1);
        nav(1'b0);
    endtask

    // five rises with the mode line left to its pull-up, then idle
    task automatic tap_reset();
        tms_drv_out = 1'b0;
        repeat (5) nav(1'b1);
        tms_drv_out = 1'b1;
        nav(1'b0);
    endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`include "bst_regs.vh"
module tb;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe_n;
    logic [`BST_USER_BITS-1:0] user_sig = 7'h5B;
    logic [`BST_BSR_LEN-1:0] pin_level = '0;
    logic [`BST_BSR_LEN-1:0] core_out = '0;
    logic [`BST_BSR_LEN-1:0] pin_out;
    logic extest, cfg_active, cfg_overrun, cfg_valid;
    logic [`BST_CFG_W-1:0] cfg_data;
    logic cfg_ready = 1'b0;
    logic clk_en = 1'b1;
    logic [`BST_CFG_W-1:0] rx_q[$];
    logic [1023:0] dout;
    int fail_count = 0;
    int tests_run = 0;

    bst_tap bst_tap_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(clk_en),
        .tck_in(tck), .tms_pad_in(tms), .tms_driven_in(tms_drv), .tdi_pad_in(tdi),
        .tdi_driven_in(tdi_drv), .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n),
        .user_sig_in(user_sig), .pin_level_in(pin_level), .core_out_in(core_out),
        .pin_out(pin_out), .extest_out(extest), .cfg_active_out(cfg_active),
        .cfg_overrun_out(cfg_overrun), .cfg_valid_out(cfg_valid), .cfg_data_out(cfg_data),
        .cfg_ready_in(cfg_ready));
    bst_jtag_host bst_jtag_host_inst (.ref_clk_in(ref_clk_in), .tdo_in(tdo), .tck_out(tck),
        .tms_out(tms), .tms_drv_out(tms_drv), .tdi_out(tdi), .tdi_drv_out(tdi_drv));

    initial begin
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in) begin
        if (cfg_valid && cfg_ready) rx_q.push_back(cfg_data);
    end

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic chk(input logic [1023:0] got, input logic [1023:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // 20-bit ir scan: capture pattern out first, then the filler proves the length
    task automatic set_ir(input logic [9:0] op);
        bst_jtag_host_inst.scan(1'b1, 20, {op, 10'h2C6}, dout);
        chk(dout[19:0], {10'h2C6, 10'h001});
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_idcode();
        bst_jtag_host_inst.scan(1'b0, 32, '0, dout);
        chk(dout[31:0], {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1});
        chk(tdo_oe_n, 1'b1);
    endtask

    task automatic t_usercode();
        set_ir(`BST_IR_USERCODE);
        bst_jtag_host_inst.scan(1'b0, 32, '0, dout);
        chk(dout[31:0], {`BST_USER_FIXED, user_sig});
    endtask

    task automatic t_bypass();
        logic [9:0] ops[2] = '{`BST_IR_BYPASS, 10'h155};
        foreach (ops[i]) begin
            set_ir(ops[i]);
            bst_jtag_host_inst.scan(1'b0, 9, 8'hB6, dout);
            chk(dout[8:0], {8'hB6, 1'b0});
        end
    endtask

    // receiver stalls: two buffered survive, the fourth byte overwrites the pending third
    task automatic t_cfg();
        int i;
        set_ir(`BST_IR_CFG);
        chk(cfg_active, 1'b1);
        bst_jtag_host_inst.scan(1'b0, 32, 32'hC3A55A3C, dout);
        chk(cfg_overrun, 1'b1);
        cfg_ready = 1'b1;
        for (i = 0; i < 40 && rx_q.size() < 3; i++) @(posedge ref_clk_in);
        if (rx_q.size() < 3) begin
            chk(rx_q.size(), 3);
            report_and_stop();
        end
        repeat (4) @(posedge ref_clk_in);
        #1;
        chk(rx_q.size(), 3);
        chk({rx_q[0], rx_q[1], rx_q[2]}, 24'h3C5AC3);
        chk(cfg_valid, 1'b0);
    endtask

    task automatic t_boundary();
        pin_level = {23{30'h2A5C3F1E}};
        core_out = ~pin_level;
        set_ir(`BST_IR_SAMPLE);
        bst_jtag_host_inst.scan(1'b0, `BST_BSR_LEN, {69{10'h3A5}}, dout);
        chk(dout[`BST_BSR_LEN-1:0], pin_level);
        chk(pin_out, core_out);
        set_ir(`BST_IR_EXTEST);
        chk(extest, 1'b1);
        chk(pin_out, {69{10'h3A5}});
        core_out = pin_level;
        bst_jtag_host_inst.scan(1'b0, `BST_BSR_LEN, {69{10'h05A}}, dout);
        chk(dout[`BST_BSR_LEN-1:0], pin_level);
        chk(pin_out, {69{10'h05A}});
    endtask

    task automatic t_tap_reset();
        bst_jtag_host_inst.tap_reset();
        chk({extest, cfg_overrun}, 2'b00);
        chk(pin_out, core_out);
        t_idcode();
    endtask

    // clock enable low freezes the pins, then they follow the core again
    task automatic t_freeze();
        logic [`BST_BSR_LEN-1:0] held;
        held = pin_out;
        clk_en = 1'b0;
        core_out = ~core_out;
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk(pin_out, held);
        clk_en = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        chk(pin_out, core_out);
    endtask

    initial begin
        repeat (6) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        repeat (4) @(posedge ref_clk_in);
        #1;
        bst_jtag_host_inst.nav(1'b0);
        t_idcode();
        t_usercode();
        t_bypass();
        t_cfg();
        t_boundary();
        t_tap_reset();
        t_freeze();
        report_and_stop();
    end
endmodule
